// ===== rtl/mpt_timer.sv
// Sixteen-bit auto-reload timer with four capture/compare/PWM channels and Avalon slave.
`timescale 1ns/1ps
// How it works
// - Sixteen-bit counter counts up, down or centre.
// - Sixteen-bit prescaler divides by one to 65536.
// - Four channels: capture, compare, PWM, one-pulse.
// - PWM is edge or centre aligned.
// - Complementary outputs with programmable dead-time.
// - Three phases drive six output lines.
// - Duty cycle reaches zero and full percent.
// - Debug halt freezes counter, forces outputs off.
// - Debug halt stops the plain counter too.
// - Trigger in and out link timers together.
// - Own DMA request lines per timer.
// - Quadrature encoder steps and steers counter.
// - Up to three hall inputs capture changes.
// - Without complement it acts as plain timer.
module mpt_timer
    import mpt_pkg::*;
(
    input  wire logic        CORE_CLK,    // System clock, 25 MHz.
    input  wire logic        RST,         // Synchronous reset, active high.
    input  wire logic [7:0]  ADDRESS,     // Avalon byte address.
    input  wire logic        READ,        // Avalon read request.
    input  wire logic        WRITE,       // Avalon write request.
    input  wire logic [31:0] WRITEDATA,   // Avalon write data.
    input  wire logic [3:0]  BYTEENABLE,  // Avalon byte lanes.
    output logic      [31:0] READDATA,    // Avalon read data.
    output logic             WAITREQUEST, // Avalon stall.
    input  wire logic [3:0]  CH_IN,       // Capture, encoder and hall pins.
    input  wire logic        DEBUG_HALT,  // Processor halted in debug.
    input  wire logic        TRIG_IN,     // Trigger from another timer.
    output logic      [3:0]  CH_OUT,      // Channel outputs.
    output logic      [2:0]  CH_OUT_N,    // Complementary outputs.
    output logic             TRIG_OUT,    // Update pulse to other timers.
    output logic      [5:0]  DMA_REQ,     // One-cycle DMA request pulses.
    output logic             IRQ          // Level interrupt.
);
    // ----------------------------------------
    // State.
    // ----------------------------------------
    logic [CTL_W-1:0] ctrl, next_ctrl;         // Control register.
    logic [15:0]      psc, next_psc;           // Prescaler reload.
    logic [15:0]      psc_cnt, next_psc_cnt;   // Prescaler counter.
    logic [15:0]      arr, next_arr;           // Auto-reload.
    logic [15:0]      cnt, next_cnt;           // Main counter.
    logic             dir_up, next_dir_up;     // Centre mode direction.
    logic [7:0]       chmode, next_chmode;     // Channel modes.
    logic [7:0]       dead, next_dead;         // Dead-time cycles.
    logic [ST_W-1:0]  stat, next_stat;         // Sticky status.
    logic [ST_W-1:0]  inten, next_inten;       // Interrupt enable.
    logic [ST_W-1:0]  dmaen, next_dmaen;       // DMA enable.
    logic [15:0]      ccr [NCH];               // Compare/capture values.
    logic [15:0]      next_ccr [NCH];          // Next compare/capture values.
    logic [NCH-1:0]   tog, next_tog;           // Compare toggle outputs.
    logic [31:0]      rdata, next_rdata;       // Read data register.
    logic             ack, next_ack;           // Access answered this cycle.
    logic [5:0]       s1, s2, s3;              // Sync stages and previous value.
    logic [ST_W-1:0]  evt;                     // Events this cycle.
    logic [NCH-1:0]   ref_w;                   // Raw channel waveforms.
    logic [31:0]      wmask;                   // Byte lane mask.
    logic             req;                     // Access pending.
    logic             halt;                    // Synchronised debug halt.

    assign req         = READ | WRITE;
    assign WAITREQUEST = req & ~ack;
    assign READDATA    = rdata;
    assign halt        = s2[4];
    assign wmask       = {{8{BYTEENABLE[3]}}, {8{BYTEENABLE[2]}},
                          {8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};
    assign IRQ         = |(stat & inten);
    assign TRIG_OUT    = evt[ST_UPD];
    assign DMA_REQ     = evt & dmaen;

    // ----------------------------------------
    // Input synchronisers.
    // ----------------------------------------
    // Pins and the other timer's trigger pass two flops; s3 holds the old value.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            s1 <= 6'h00;
            s2 <= 6'h00;
            s3 <= 6'h00;
        end else begin
            s1 <= {TRIG_IN, DEBUG_HALT, CH_IN};
            s2 <= s1;
            s3 <= s2;
        end
    end

    // ----------------------------------------
    // Next-state logic.
    // ----------------------------------------
    // Bus access, counter, channels and status all update here.
    always_comb begin
        logic        frz;
        logic        step;
        logic        up;
        logic        moved;
        logic [15:0] wr16;
        frz = 1'b0;
        step = 1'b0;
        up = 1'b1;
        moved = 1'b0;
        wr16 = 16'h0000;
        next_ctrl = ctrl;
        next_psc = psc;
        next_psc_cnt = psc_cnt;
        next_arr = arr;
        next_cnt = cnt;
        next_dir_up = dir_up;
        next_chmode = chmode;
        next_dead = dead;
        next_inten = inten;
        next_dmaen = dmaen;
        next_tog = tog;
        next_ccr = ccr;
        evt = '0;
        next_ack = req & ~ack;
        next_rdata = rdata;
        // Debug halt freezes counter and prescaler when asked.
        frz = halt & ctrl[CTL_DBGF];
        if (ctrl[CTL_ENC]) begin
            // Any edge on either encoder line steps; phase gives direction.
            step = (s2[0] ^ s3[0]) | (s2[1] ^ s3[1]);
            up   = s3[0] ^ s2[1];
        end else if (ctrl[CTL_EN] && !frz) begin
            // Prescaler gives one tick every psc+1 cycles.
            if (psc_cnt >= psc) begin
                next_psc_cnt = 16'h0000;
                step = 1'b1;
            end else begin
                next_psc_cnt = psc_cnt + 16'h0001;
            end
            up = (ctrl[CTL_MODE+:2] == CM_UP) ||
                 (ctrl[CTL_MODE+:2] == CM_CENTER && dir_up);
        end
        if (step && ctrl[CTL_EN] && !frz) begin
            moved = 1'b1;
            if (up) begin
                if (cnt >= arr) begin
                    // Top reached: wrap, or turn round in centre mode.
                    evt[ST_UPD] = 1'b1;
                    if (ctrl[CTL_MODE+:2] == CM_CENTER && !ctrl[CTL_ENC]) begin
                        next_dir_up = 1'b0;
                        next_cnt = arr - 16'h0001;
                    end else begin
                        next_cnt = 16'h0000;
                    end
                end else begin
                    next_cnt = cnt + 16'h0001;
                end
            end else begin
                if (cnt == 16'h0000) begin
                    // Bottom reached: reload, or turn round in centre mode.
                    evt[ST_UPD] = 1'b1;
                    if (ctrl[CTL_MODE+:2] == CM_CENTER && !ctrl[CTL_ENC]) begin
                        next_dir_up = 1'b1;
                        next_cnt = 16'h0001;
                    end else begin
                        next_cnt = arr;
                    end
                end else begin
                    next_cnt = cnt - 16'h0001;
                end
            end
            // One-pulse mode stops the counter at its update.
            if (evt[ST_UPD] && ctrl[CTL_OPM]) begin
                next_ctrl[CTL_EN] = 1'b0;
            end
        end
        // Rising trigger from a linked timer.
        evt[ST_TRG] = s2[5] & ~s3[5];
        if (evt[ST_TRG] && ctrl[CTL_TRST]) begin
            next_cnt = 16'h0000;
            next_psc_cnt = 16'h0000;
            next_dir_up = 1'b1;
        end
        // Channels: capture on edge, flag and toggle on match.
        for (int i = 0; i < NCH; i++) begin
            ref_w[i] = 1'b0;
            case (chmode[2*i+:2])
                CH_CAPT: begin
                    // Channel 0 in hall mode sees any change of three sensors.
                    if (i == 0 && ctrl[CTL_HALL]) begin
                        evt[ST_CH] = ^(s2[2:0] ^ s3[2:0]) | (s2[2:0] != s3[2:0]);
                    end else begin
                        evt[ST_CH+i] = s2[i] & ~s3[i];
                    end
                    if (evt[ST_CH+i]) begin
                        next_ccr[i] = cnt;
                    end
                end
                CH_CMP: begin
                    evt[ST_CH+i] = moved && (next_cnt == ccr[i]);
                    if (evt[ST_CH+i]) begin
                        next_tog[i] = ~tog[i];
                    end
                    ref_w[i] = tog[i];
                end
                CH_PWM: begin
                    // Zero gives 0 %, above reload gives 100 %.
                    evt[ST_CH+i] = moved && (next_cnt == ccr[i]);
                    ref_w[i] = cnt < ccr[i];
                end
                default: begin
                    ref_w[i] = 1'b0;
                end
            endcase
        end
        // Bus write, honouring byte lanes.
        wr16 = 16'(WRITEDATA & wmask);
        if (WRITE && !ack) begin
            if (ADDRESS == OFS_CTRL) begin
                next_ctrl = CTL_W'((32'(ctrl) & ~wmask) | (WRITEDATA & wmask));
            end else if (ADDRESS == OFS_PSC) begin
                next_psc = (psc & ~wmask[15:0]) | wr16;
            end else if (ADDRESS == OFS_ARR) begin
                next_arr = (arr & ~wmask[15:0]) | wr16;
            end else if (ADDRESS == OFS_CNT) begin
                next_cnt = (cnt & ~wmask[15:0]) | wr16;
            end else if (ADDRESS == OFS_CHMODE) begin
                next_chmode = (chmode & ~wmask[7:0]) | wr16[7:0];
            end else if (ADDRESS == OFS_DEAD) begin
                next_dead = (dead & ~wmask[7:0]) | wr16[7:0];
            end else if (ADDRESS == OFS_INTEN) begin
                next_inten = (inten & ~wmask[5:0]) | wr16[5:0];
            end else if (ADDRESS == OFS_DMAEN) begin
                next_dmaen = (dmaen & ~wmask[5:0]) | wr16[5:0];
            end else if (ADDRESS >= OFS_CCR0 && ADDRESS <= OFS_CCR0 + 8'h0c) begin
                next_ccr[2'(ADDRESS[3:2] - OFS_CCR0[3:2])] =
                    (ccr[2'(ADDRESS[3:2] - OFS_CCR0[3:2])] & ~wmask[15:0]) | wr16;
            end
        end
        // Status: a new event wins over a clear in the same cycle.
        next_stat = stat;
        if (WRITE && !ack && ADDRESS == OFS_INTCLR) begin
            next_stat = stat & ~(WRITEDATA[5:0] & wmask[5:0]);
        end
        next_stat = next_stat | evt;
        // Bus read; unmapped addresses read as zero.
        if (READ && !ack) begin
            if (ADDRESS == OFS_CTRL) begin
                next_rdata = 32'(ctrl);
            end else if (ADDRESS == OFS_PSC) begin
                next_rdata = 32'(psc);
            end else if (ADDRESS == OFS_ARR) begin
                next_rdata = 32'(arr);
            end else if (ADDRESS == OFS_CNT) begin
                next_rdata = 32'(cnt);
            end else if (ADDRESS == OFS_CHMODE) begin
                next_rdata = 32'(chmode);
            end else if (ADDRESS == OFS_DEAD) begin
                next_rdata = 32'(dead);
            end else if (ADDRESS == OFS_STAT) begin
                next_rdata = 32'(stat);
            end else if (ADDRESS == OFS_INTEN) begin
                next_rdata = 32'(inten);
            end else if (ADDRESS == OFS_DMAEN) begin
                next_rdata = 32'(dmaen);
            end else if (ADDRESS >= OFS_CCR0 && ADDRESS <= OFS_CCR0 + 8'h0c) begin
                next_rdata = 32'(ccr[2'(ADDRESS[3:2] - OFS_CCR0[3:2])]);
            end else begin
                next_rdata = 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // Registers.
    // ----------------------------------------
    // Counter powers up with reload at top and the prescaler at divide by one.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ctrl <= '0;
            psc <= 16'h0000;
            psc_cnt <= 16'h0000;
            arr <= CNT_MAX;
            cnt <= 16'h0000;
            dir_up <= 1'b1;
            chmode <= 8'hff;
            dead <= 8'h00;
            stat <= '0;
            inten <= '0;
            dmaen <= '0;
            tog <= '0;
            rdata <= 32'h0000_0000;
            ack <= 1'b0;
            for (int i = 0; i < NCH; i++) begin
                ccr[i] <= 16'h0000;
            end
        end else begin
            ctrl <= next_ctrl;
            psc <= next_psc;
            psc_cnt <= next_psc_cnt;
            arr <= next_arr;
            cnt <= next_cnt;
            dir_up <= next_dir_up;
            chmode <= next_chmode;
            dead <= next_dead;
            stat <= next_stat;
            inten <= next_inten;
            dmaen <= next_dmaen;
            tog <= next_tog;
            rdata <= next_rdata;
            ack <= next_ack;
            ccr <= next_ccr;
        end
    end

    // ----------------------------------------
    // Output stages with dead-time.
    // ----------------------------------------
    // With complementary outputs on, channels 0 to 2 wait dead cycles after their waveform turns before either side drives.
    for (genvar g = 0; g < NCH; g++) begin : g_out
        logic [7:0] dt, next_dt;   // Cycles since the waveform last changed.
        logic       rq, next_rq;   // Previous waveform.
        logic       op, next_op;   // Next main output.
        logic       on, next_on;   // Next complementary output.
        always_comb begin
            next_rq = ref_w[g];
            next_dt = (ref_w[g] != rq) ? 8'h00 : ((dt == 8'hff) ? dt : dt + 8'h01);
            if (ctrl[CTL_COMP] && g < 3) begin
                next_op = ref_w[g] & (next_dt >= dead);
                next_on = ~ref_w[g] & (next_dt >= dead);
            end else begin
                next_op = ref_w[g];
                next_on = 1'b0;
            end
            // Debug halt turns every power switch off.
            if (halt && ctrl[CTL_DBGO]) begin
                next_op = 1'b0;
                next_on = 1'b0;
            end
        end
        always_ff @(posedge CORE_CLK) begin
            if (RST) begin
                dt <= 8'h00;
                rq <= 1'b0;
                op <= 1'b0;
                on <= 1'b0;
            end else begin
                dt <= next_dt;
                rq <= next_rq;
                op <= next_op;
                on <= next_on;
            end
        end
        assign CH_OUT[g] = op;
        if (g < 3) begin : g_n
            assign CH_OUT_N[g] = on;
        end
    end
endmodule

// ===== rtl/mpt_pkg.sv
// Package of register map, field layout and enumerations for the PWM capture timer.
package mpt_pkg;
    // ----------------------------------------
    // Register byte offsets.
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00; // Control register.
    localparam logic [7:0] OFS_PSC    = 8'h04; // Prescaler divide minus one.
    localparam logic [7:0] OFS_ARR    = 8'h08; // Auto-reload value.
    localparam logic [7:0] OFS_CNT    = 8'h0c; // Counter value.
    localparam logic [7:0] OFS_CHMODE = 8'h10; // Two mode bits per channel.
    localparam logic [7:0] OFS_DEAD   = 8'h14; // Dead-time in clock cycles.
    localparam logic [7:0] OFS_STAT   = 8'h18; // Sticky event status.
    localparam logic [7:0] OFS_INTEN  = 8'h1c; // Interrupt enable.
    localparam logic [7:0] OFS_INTCLR = 8'h20; // Write one to clear status.
    localparam logic [7:0] OFS_DMAEN  = 8'h24; // DMA request enable.
    localparam logic [7:0] OFS_CCR0   = 8'h28; // First compare/capture value.
    // ----------------------------------------
    // Control register fields.
    // ----------------------------------------
    localparam int CTL_EN    = 0; // Counter enable.
    localparam int CTL_MODE  = 1; // Two bits: count mode.
    localparam int CTL_OPM   = 3; // One-pulse: stop at update.
    localparam int CTL_COMP  = 4; // Complementary outputs with dead-time.
    localparam int CTL_DBGF  = 5; // Freeze counter in debug halt.
    localparam int CTL_DBGO  = 6; // Force outputs off in debug halt.
    localparam int CTL_ENC   = 7; // Quadrature encoder clocking.
    localparam int CTL_HALL  = 8; // Hall sensor capture on channel 0.
    localparam int CTL_TRST  = 9; // Trigger input resets the counter.
    localparam int CTL_W     = 10; // Width of control register.
    // ----------------------------------------
    // Status bit positions and widths.
    // ----------------------------------------
    localparam int ST_UPD  = 0; // Update event.
    localparam int ST_CH   = 1; // Four channel flags from here.
    localparam int ST_TRG  = 5; // Trigger input event.
    localparam int ST_W    = 6; // Number of status bits.
    localparam int NCH     = 4; // Number of channels.
    localparam logic [15:0] CNT_MAX = 16'hffff; // Counter and prescaler top.
    // ----------------------------------------
    // Enumerations.
    // ----------------------------------------
    typedef enum logic [1:0] {CM_UP, CM_DOWN, CM_CENTER, CM_RSV} mpt_cmode_t;
    typedef enum logic [1:0] {CH_CAPT, CH_CMP, CH_PWM, CH_OFF} mpt_chmode_t;
endpackage

// ===== verif/mpt_timer_sva.sv
// Port checker for the motor PWM capture timer.
`timescale 1ns/1ps
module mpt_timer_sva
    import mpt_pkg::*;
(
    input wire logic        CORE_CLK,
    input wire logic        RST,
    input wire logic [7:0]  ADDRESS,
    input wire logic        READ,
    input wire logic        WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0]  BYTEENABLE,
    input wire logic [31:0] READDATA,
    input wire logic        WAITREQUEST,
    input wire logic [3:0]  CH_IN,
    input wire logic        DEBUG_HALT,
    input wire logic        TRIG_IN,
    input wire logic [3:0]  CH_OUT,
    input wire logic [2:0]  CH_OUT_N,
    input wire logic        TRIG_OUT,
    input wire logic [5:0]  DMA_REQ,
    input wire logic        IRQ
);
    // ----------------------------------------
    // One clock domain, reset disables all.
    // ----------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    // ----------------------------------------
    // Bus, event and output relations.
    // ----------------------------------------
    bus_wait_a: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
        else $error("bus answer later than one wait state");
    bus_idle_a: assert property (!READ && !WRITE |-> !WAITREQUEST)
        else $error("wait raised without a request");
    read_hold_a: assert property ($changed(READDATA) |-> READ && !WAITREQUEST)
        else $error("read data moved outside a read answer");
    trig_pulse_a: assert property (TRIG_OUT |=> !TRIG_OUT)
        else $error("trigger output longer than one cycle");
    dma_pulse_a: assert property (DMA_REQ != 6'h0 |=> (DMA_REQ & $past(DMA_REQ)) == 6'h0)
        else $error("dma request longer than one cycle");
    dma_update_a: assert property (DMA_REQ[0] |-> TRIG_OUT)
        else $error("update request without update pulse");
    reset_quiet_a: assert property ($fell(RST) |-> CH_OUT == 4'h0 && CH_OUT_N == 3'h0
        && DMA_REQ == 6'h0 && !IRQ && !TRIG_OUT)
        else $error("outputs active after reset");
    dead_gap_a: assert property ((CH_OUT[2:0] & CH_OUT_N) == 3'h0)
        else $error("output and complement high together");
    // Main scenarios reached.
    cover property (TRIG_OUT && IRQ);
    cover property (CH_OUT_N[0]);
    cover property (DMA_REQ[3]);
endmodule
bind mpt_timer mpt_timer_sva chk_u (
    .CORE_CLK(CORE_CLK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .CH_IN(CH_IN), .DEBUG_HALT(DEBUG_HALT),
    .TRIG_IN(TRIG_IN), .CH_OUT(CH_OUT), .CH_OUT_N(CH_OUT_N), .TRIG_OUT(TRIG_OUT),
    .DMA_REQ(DMA_REQ), .IRQ(IRQ)
);

// ===== verif/mpt_pins_model.sv
// Model of the encoder and sensor pins in front of the timer.
`timescale 1ns/1ps
module mpt_pins_model (
    input  wire logic       clk,
    input  wire logic       step,
    input  wire logic [1:0] cap,
    output logic      [3:0] pins
);
    // Gray-coded encoder position, so one line moves per step.
    logic [1:0] phase = 2'h0;
    // Advance the quadrature pair by one edge.
    always_ff @(posedge clk) begin
        if (step) begin
            phase <= {phase[0], ~phase[1]};
        end
    end
    // Upper pins are plain sensor levels from the bench.
    assign pins = {cap, phase};
endmodule

// ===== verif/tb.sv
// Self-checking bench for the motor PWM capture timer.
`timescale 1ns/1ps
module tb
    import mpt_pkg::*;
;
    logic        CORE_CLK = 1'b0;
    logic        RST = 1'b1;
    logic [7:0]  ADDRESS = 8'h00;
    logic        READ = 1'b0;
    logic        WRITE = 1'b0;
    logic [31:0] WRITEDATA = 32'h0;
    logic [31:0] READDATA;
    logic        WAITREQUEST;
    logic [3:0]  CH_IN;
    logic        DEBUG_HALT = 1'b0;
    logic        TRIG_IN = 1'b0;
    logic [3:0]  CH_OUT;
    logic [2:0]  CH_OUT_N;
    logic        TRIG_OUT;
    logic [5:0]  DMA_REQ;
    logic        IRQ;
    logic        step = 1'b0;
    logic [1:0]  cap = 2'h0;
    logic [31:0] rng = 32'h739e85e5;
    logic [31:0] q;
    logic [7:0]  tbl [7] = '{OFS_PSC, OFS_ARR, OFS_CNT, 8'h28, 8'h2c, 8'h30, 8'h34};
    int          cv [3] = '{0, 4, 10};
    int          num_errors = 0;
    int          checked = 0;
    int          n;
    // Clock of 40 ns period.
    always #20 CORE_CLK = ~CORE_CLK;
    mpt_timer dut_u (.CORE_CLK(CORE_CLK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ),
        .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(4'hf), .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST), .CH_IN(CH_IN), .DEBUG_HALT(DEBUG_HALT),
        .TRIG_IN(TRIG_IN), .CH_OUT(CH_OUT), .CH_OUT_N(CH_OUT_N), .TRIG_OUT(TRIG_OUT),
        .DMA_REQ(DMA_REQ), .IRQ(IRQ));
    mpt_pins_model pins_u (.clk(CORE_CLK), .step(step), .cap(cap), .pins(CH_IN));
    // ----------------------------------------
    // Reference model and bus tasks.
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // High cycles of channel 0 over one period, ARR of 9.
    function automatic int duty(input int m, input int c);
        if (m == 0) begin
            return (c > 10) ? 10 : c;
        end
        return (c == 0) ? 0 : (c > 9) ? 18 : 2 * c - 1;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h wanted %h", $time, m, got, exp);
        end
    endtask
    // One Avalon transfer, held until the answering edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        ADDRESS <= a;
        WRITEDATA <= d;
        WRITE <= w;
        READ <= ~w;
        // Wait for the rising edge at which the stall is sampled low.
        @(posedge CORE_CLK);
        while (WAITREQUEST !== 1'b0) begin
            @(posedge CORE_CLK);
        end
        r = READDATA;
        WRITE <= 1'b0;
        READ <= 1'b0;
        @(posedge CORE_CLK);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
        bus(1'b0, a, 32'h0, q);
        chk(q, e, m);
    endtask
    // Cycles from one update pulse to the next.
    task automatic gap(output int g);
        int t;
        t = 0;
        while (TRIG_OUT !== 1'b1 && t < 900) begin
            @(negedge CORE_CLK);
            t++;
        end
        g = 0;
        do begin
            @(negedge CORE_CLK);
            g++;
        end while (TRIG_OUT !== 1'b1 && g < 900);
    endtask
    // High cycles of output 0 and its complement over a window.
    task automatic hi(input int len, output int h);
        h = 0;
        repeat (len) begin
            @(negedge CORE_CLK);
            h += int'(CH_OUT[0] === 1'b1) + int'(CH_OUT_N[0] === 1'b1);
        end
        @(posedge CORE_CLK);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios.
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge CORE_CLK);
        RST <= 1'b0;
        @(posedge CORE_CLK);
        for (int a = 0; a <= 'h38; a += 4) begin
            if (a != 'h20) begin
                rd(8'(a), (a == 8) ? 32'hffff : (a == 'h10) ? 32'hff : 32'h0, "reset");
            end
        end
        for (int i = 0; i < 7; i++) begin
            rng = lfsr(rng);
            wr(tbl[i], rng);
            rd(tbl[i], rng & 32'hffff, "readback");
        end
        wr(OFS_STAT, 32'hffffffff);
        rd(OFS_STAT, 32'h0, "status read-only");
        $display("test registers done");
        wr(OFS_PSC, 32'h2);
        wr(OFS_ARR, 32'h5);
        wr(OFS_INTEN, 32'h1);
        wr(OFS_DMAEN, 32'h1);
        for (int m = 0; m < 3; m++) begin
            wr(OFS_CNT, 32'h0);
            wr(OFS_CTRL, 32'(1 + 2 * m));
            gap(n);
            chk(n, (m == 2) ? 15 : 18, "update spacing");
            @(posedge CORE_CLK);
        end
        wr(OFS_CTRL, 32'h0);
        chk(IRQ, 1'b1, "irq raised");
        wr(OFS_INTEN, 32'h0);
        chk(IRQ, 1'b0, "irq masked");
        wr(OFS_INTCLR, 32'h3f);
        rd(OFS_STAT, 32'h0, "status cleared");
        $display("test counting done");
        wr(OFS_PSC, 32'h0);
        wr(OFS_ARR, 32'h9);
        wr(OFS_CHMODE, 32'hfe);
        for (int m = 0; m < 3; m += 2) begin
            foreach (cv[j]) begin
                wr(OFS_CCR0, cv[j]);
                wr(OFS_CTRL, 32'(1 + 2 * m));
                gap(n);
                hi((m == 2) ? 18 : 10, n);
                chk(n, duty(m, cv[j]), "pwm high time");
            end
        end
        wr(OFS_DEAD, 32'h2);
        wr(OFS_CCR0, 32'h4);
        wr(OFS_CTRL, 32'h11);
        gap(n);
        hi(10, n);
        chk(n, 6, "dead band");
        $display("test pwm done");
        wr(OFS_CTRL, 32'h71);
        DEBUG_HALT <= 1'b1;
        repeat (6) @(posedge CORE_CLK);
        bus(1'b0, OFS_CNT, 32'h0, q);
        rd(OFS_CNT, q, "frozen count");
        chk({CH_OUT, 1'b0, CH_OUT_N}, 32'h0, "outputs off");
        DEBUG_HALT <= 1'b0;
        wr(OFS_CTRL, 32'h0);
        wr(OFS_ARR, 32'hffff);
        wr(OFS_CNT, 32'h0);
        wr(OFS_CTRL, 32'h81);
        repeat (6) begin
            step <= 1'b1;
            @(posedge CORE_CLK);
            step <= 1'b0;
            repeat (4) @(posedge CORE_CLK);
        end
        bus(1'b0, OFS_CNT, 32'h0, q);
        chk(32'((q === 32'h6) || (q === 32'hfffa)), 32'h1, "encoder count");
        $display("test debug and encoder done");
        wr(OFS_CTRL, 32'h0);
        wr(OFS_INTCLR, 32'h3f);
        wr(OFS_DMAEN, 32'h8);
        wr(OFS_CHMODE, 32'hcf);
        wr(OFS_CNT, 32'h0);
        wr(OFS_CTRL, 32'h1);
        cap <= 2'h1;
        n = 0;
        repeat (10) begin
            @(negedge CORE_CLK);
            n += int'(DMA_REQ[3] === 1'b1);
        end
        @(posedge CORE_CLK);
        chk(n, 1, "capture request");
        rd(OFS_STAT, 32'h8, "capture flag");
        wr(OFS_CHMODE, 32'hfc);
        wr(OFS_CTRL, 32'h101);
        wr(OFS_INTCLR, 32'h3f);
        cap <= 2'h0;
        repeat (6) @(posedge CORE_CLK);
        rd(OFS_STAT, 32'h2, "hall capture");
        wr(OFS_CTRL, 32'h201);
        wr(OFS_INTCLR, 32'h3f);
        TRIG_IN <= 1'b1;
        repeat (6) @(posedge CORE_CLK);
        rd(OFS_STAT, 32'h20, "trigger flag");
        $display("test capture and trigger done");
        end_sim();
    end
    // Watchdog well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        num_errors++;
        end_sim();
    end
endmodule
